/* File: testbench.sv */
/*
 Self-checking bench for uhs_top with a modem model at the far end.
 Assumes host pins are synced inside, so strobes hold four edges.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic masterClear = 1'b0;
	logic [2:0] sel = 3'h0;
	logic strobeN = 1'b0;
	logic [2:0] cs = 3'h4;
	logic [3:0] strb = 4'h0;
	logic [7:0] drv = 8'h00;
	logic [3:0] act = 4'h0;
	logic slow = 1'b0;
	logic [2:0] cause = 3'h0;
	logic fifoMode = 1'b0;
	logic thrEmpty = 1'b0;
	logic rxAbove = 1'b0;
	int nThr = 0;
	logic oeSeen;
	logic [2:0] bad;
	logic [7:0] q;
	logic [7:0] isrExp [3] = '{8'h06, 8'h04, 8'hcc};
	logic [7:0] hostDataIn, hostDataOut, thrData, lineControl;
	logic hostDataOe, transceiverDisableN, interruptOut, dtrN, rtsN;
	logic txSixteenxClockOut, txAllowed, thrWrite, ctsN, dsrN, dcdN, riN;
	int h, m;
	int mismatches = 0;
	int nCompared = 0;
	// Bus level: chip drives while enabled, host otherwise
	assign hostDataIn = hostDataOe ? hostDataOut : drv;
	uhs_modem_model modem (.clock, .active(act), .slow, .ctsN, .dsrN,
		.riN, .dcdN);
	uhs_top uut (.clock, .rst, .masterClear, .registerSelectLines(sel),
		.selectLatchStrobeN(strobeN), .chipEnableHighA(cs[2]),
		.chipEnableHighB(cs[1]), .chipEnableLowN(cs[0]),
		.hostReadStrobeN(~strb[0]), .hostReadStrobe(strb[1]),
		.hostWriteStrobeN(~strb[2]), .hostWriteStrobe(strb[3]),
		.hostDataIn, .hostDataOut, .hostDataOe, .transceiverDisableN,
		.interruptOut, .ctsN, .dsrN, .dcdN, .riN, .dtrN, .rtsN,
		.txSixteenxClockOut, .txAllowed, .fifoMode,
		.rxDataReady(cause[1]), .rxTimeout(cause[2]),
		.rxLineError(cause[0]), .rxAboveThreshold(rxAbove), .thrEmpty,
		.rxHoldData(8'h00), .lineStatus(8'h00), .thrWrite, .thrData,
		.lineControl);
	// Count transmit strobes on the far edge, away from their launch
	always @(negedge clock) begin
		nThr += thrWrite;
	end
	// Free-running clock
	initial begin
		forever #25 clock = ~clock;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#5;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		nCompared++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One host cycle: kind 0 rd low, 1 rd high, 2 wr low, 3 wr high
	task automatic acc(input logic [2:0] a, input logic [1:0] kind,
		input logic [7:0] d, input logic [2:0] c, output logic [7:0] r);
		sel = a;
		cs = c;
		drv = d;
		tick(2);
		strb = 4'h1 << kind;
		tick(4);
		r = hostDataOut;
		oeSeen = hostDataOe & transceiverDisableN;
		strb = 4'h0;
		tick(3);
		cs = 3'h4;
		tick(2);
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d,
		input logic hi);
		acc(a, {1'b1, hi}, d, 3'h6, q);
	endtask
	task automatic rdc(input logic [2:0] a, input logic [7:0] e,
		input logic hi);
		acc(a, {1'b0, hi}, 8'h00, 3'h6, q);
		chk(q, e);
		chk({7'h0, oeSeen}, 8'h01);
	endtask
	task automatic end_sim;
		$display("compared=%0d mismatches=%0d", nCompared, mismatches);
		if (mismatches == 0 && nCompared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Watchdog well beyond the expected run of about 600 cycles
	initial begin
		#200000;
		mismatches++;
		end_sim();
	end
	initial begin
		tick(12);
		rst = 1'b0;
		tick(2);
		chk({dtrN, rtsN, interruptOut, hostDataOe, transceiverDisableN,
			txSixteenxClockOut, txAllowed, thrWrite}, 8'hc2);
		wr(3'h7, 8'ha5, 1'b0);
		rdc(3'h7, 8'ha5, 1'b1);
		wr(3'h7, 8'h5a, 1'b1);
		rdc(3'h7, 8'h5a, 1'b0);
		// Any one enable off must leave the chip deaf and quiet
		for (int i = 0; i < 3; i++) begin
			bad = 3'h6 ^ (3'h4 >> i);
			acc(3'h7, 2'h2, 8'hff, bad, q);
			acc(3'h7, 2'h0, 8'h00, bad, q);
			chk({7'h0, oeSeen}, 8'h00);
		end
		rdc(3'h7, 8'h5a, 1'b0);
		// Latch selects, then scramble them under the held strobe
		sel = 3'h7;
		cs = 3'h6;
		tick(3);
		strobeN = 1'b1;
		tick(3);
		acc(3'h3, 2'h2, 8'h3c, 3'h1, q);
		strobeN = 1'b0;
		rdc(3'h7, 8'h3c, 1'b0);
		rdc(3'h3, 8'h00, 1'b0);
		wr(3'h1, 8'h08, 1'b0);
		// Send-clear, set-ready and carrier, prompt and slow modem
		for (int k = 0; k < 3; k++) begin
			m = (k == 2) ? 3 : k;
			slow = k[0];
			act[m] = 1'b1;
			tick(8);
			chk({7'h0, interruptOut}, 8'h01);
			rdc(3'h6, 8'h11 << m, 1'b1);
			rdc(3'h6, 8'h10 << m, 1'b0);
			chk({7'h0, interruptOut}, 8'h00);
			act[m] = 1'b0;
			tick(8);
			rdc(3'h6, 8'h01 << m, 1'b0);
		end
		wr(3'h4, 8'h20, 1'b0);
		act[0] = 1'b1;
		tick(8);
		chk({6'h0, interruptOut, txAllowed}, 8'h01);
		act[0] = 1'b0;
		tick(8);
		chk({6'h0, interruptOut, txAllowed}, 8'h00);
		rdc(3'h6, 8'h01, 1'b0);
		wr(3'h4, 8'h01, 1'b0);
		chk({7'h0, dtrN}, 8'h00);
		wr(3'h4, 8'h11, 1'b0);
		chk({7'h0, dtrN}, 8'h01);
		rdc(3'h6, 8'h22, 1'b0);
		wr(3'h4, 8'h03, 1'b0);
		chk({6'h0, interruptOut, dtrN}, 8'h02);
		// Auto mode, send-request bit set: receive threshold decides send request
		wr(3'h4, 8'h23, 1'b0);
		rxAbove = 1'b1;
		tick(1);
		chk({7'h0, rtsN}, 8'h01);
		rxAbove = 1'b0;
		tick(1);
		chk({7'h0, rtsN}, 8'h00);
		masterClear = 1'b1;
		tick(4);
		chk({5'h0, interruptOut, dtrN, rtsN}, 8'h03);
		masterClear = 1'b0;
		tick(3);
		rdc(3'h1, 8'h00, 1'b0);
		chk({6'h0, interruptOut, dtrN}, 8'h01);
		wr(3'h1, 8'h07, 1'b0);
		// Line error, data ready, then timeout in buffered mode
		for (int k = 0; k < 3; k++) begin
			fifoMode = (k == 2);
			cause = 3'h1 << k;
			tick(2);
			chk({7'h0, interruptOut}, 8'h01);
			rdc(3'h2, isrExp[k], 1'b0);
			cause = 3'h0;
			tick(2);
			chk({7'h0, interruptOut}, 8'h00);
		end
		fifoMode = 1'b0;
		thrEmpty = 1'b1;
		tick(2);
		chk({7'h0, interruptOut}, 8'h01);
		rdc(3'h2, 8'h02, 1'b0);
		chk({7'h0, interruptOut}, 8'h00);
		wr(3'h3, 8'h80, 1'b0);
		wr(3'h0, 8'h05, 1'b0);
		wr(3'h1, 8'h00, 1'b0);
		wr(3'h3, 8'h03, 1'b0);
		wr(3'h0, 8'h77, 1'b1);
		chk(thrData, 8'h77);
		chk(lineControl, 8'h03);
		chk(nThr[7:0], 8'h01);
		// Divisor five: high two of every five cycles
		h = 0;
		repeat (40) begin
			tick(1);
			h += txSixteenxClockOut;
		end
		chk(h[7:0], 8'h10);
		end_sim();
	end
endmodule
`default_nettype wire

/* File: uhs_baud_gen.sv */
/*
 Divider that makes the 16x transmit clock from the reference clock.
 Assumes the divisor is static between writes; a change restarts
 the count at its next wrap.
*/
`timescale 1ns/1ns
`default_nettype none

module uhs_baud_gen (
	input wire logic clock,
	input wire logic rst,
	uhs_baud_if.gen link
);

	typedef struct packed {
		logic [uhs_pkg::DIV_W-1:0] count;
		logic level;
	} uhs_baud_state_type;

	uhs_baud_state_type st_q;
	uhs_baud_state_type st_d;
	logic [uhs_pkg::DIV_W-1:0] lastCount;
	logic [uhs_pkg::DIV_W-1:0] halfCount;

	assign lastCount = link.divisor - uhs_pkg::DIV_ONE;
	assign halfCount = link.divisor >> 1;

	// Count 0..divisor-1, high for the first half of each period
	always_comb begin
		st_d = st_q;
		if (link.divisor == uhs_pkg::DIV_RESET) begin
			// Zero divisor stops the clock rather than dividing by 2^16
			st_d.count = uhs_pkg::DIV_RESET;
			st_d.level = 1'b0;
		end else if (link.divisor == uhs_pkg::DIV_ONE) begin
			// Full-rate output cannot come from a register; held high
			st_d.count = uhs_pkg::DIV_RESET;
			st_d.level = 1'b1;
		end else begin
			if (st_q.count >= lastCount) begin
				st_d.count = uhs_pkg::DIV_RESET;
			end else begin
				st_d.count = st_q.count + uhs_pkg::DIV_ONE;
			end
			st_d.level = (st_d.count < halfCount);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign link.sixteenx = st_q.level;

endmodule

`default_nettype wire

/* File: uhs_baud_if.sv */
/*
 Carrier between the register front end and the baud divider.
 Assumes both ends share the block clock.
*/
`timescale 1ns/1ns
`default_nettype none

interface uhs_baud_if;
	logic [uhs_pkg::DIV_W-1:0] divisor;
	logic sixteenx;

	modport gen (input divisor, output sixteenx);
	modport user (output divisor, input sixteenx);
endinterface

`default_nettype wire

/* File: uhs_modem_model.sv */
/*
 Far-end modem model: drives the four active-low status pins.
 Assumes the bench says which lines are active; slow adds a cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module uhs_modem_model (
	input wire logic clock,
	input wire logic [3:0] active,
	input wire logic slow,
	output logic ctsN,
	output logic dsrN,
	output logic riN,
	output logic dcdN
);
	logic [3:0] early = 4'hf;
	logic [3:0] pinsN = 4'hf;
	// Pulled-up lines: idle is the inactive high level
	always @(posedge clock) begin
		early <= ~active;
		pinsN <= slow ? early : ~active;
	end
	assign {dcdN, riN, dsrN, ctsN} = pinsN;
endmodule
`default_nettype wire

/* File: uhs_pkg.sv */
/*
 Shared constants for the UART host-select and modem-pin block:
 register indices, field positions, interrupt identity codes, widths.
 Assumes a single 20 MHz clock; nothing else is needed to compile it.
*/
`default_nettype none

package uhs_pkg;

	// Widths
	localparam int DATA_W = 8;
	localparam int ADDR_W = 3;
	localparam int DIV_W = 16;
	localparam int SYNC_W = 24;
	// Synchroniser idle image: active-low pins high except the latch strobe, all else low
	localparam logic [SYNC_W-1:0] SYNC_IDLE = 24'h7802c0;

	// Register indices on the select lines
	localparam logic [2:0] REG_RXTX = 3'h0;
	localparam logic [2:0] REG_IER = 3'h1;
	localparam logic [2:0] REG_ISR = 3'h2;
	localparam logic [2:0] REG_LCR = 3'h3;
	localparam logic [2:0] REG_MCR = 3'h4;
	localparam logic [2:0] REG_LSR = 3'h5;
	localparam logic [2:0] REG_MSR = 3'h6;
	localparam logic [2:0] REG_SPR = 3'h7;

	// Interrupt enable bits
	localparam int IER_RX = 0;
	localparam int IER_THRE = 1;
	localparam int IER_LINE = 2;
	localparam int IER_MODEM = 3;

	// Line control: divisor latch access
	localparam int LCR_DLAB = 7;

	// Modem control bits
	localparam int MCR_DTR = 0;
	localparam int MCR_RTS = 1;
	localparam int MCR_OUT1 = 2;
	localparam int MCR_OUT2 = 3;
	localparam int MCR_LOOP = 4;
	localparam int MCR_AFE = 5;

	// Modem input index; status bit is index plus four, delta bit is index
	localparam int MDM_CTS = 0;
	localparam int MDM_DSR = 1;
	localparam int MDM_RI = 2;
	localparam int MDM_DCD = 3;

	// Interrupt identity codes, low nibble of the identity register
	localparam logic [3:0] ISR_NONE = 4'h1;
	localparam logic [3:0] ISR_LINE = 4'h6;
	localparam logic [3:0] ISR_RXDATA = 4'h4;
	localparam logic [3:0] ISR_TIMEOUT = 4'hc;
	localparam logic [3:0] ISR_THRE = 4'h2;
	localparam logic [3:0] ISR_MODEM = 4'h0;
	localparam logic [1:0] ISR_FIFO_ON = 2'h3;
	localparam logic [1:0] ISR_FIFO_OFF = 2'h0;

	// Reset values and the divisor of one
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [DIV_W-1:0] DIV_RESET = 16'h0000;
	localparam logic [DIV_W-1:0] DIV_ONE = 16'h0001;

endpackage

`default_nettype wire

/* File: uhs_props.sv */
/*
 Pin-level checker for uhs_top.
 Assumes 2FF-synced host and modem pins and the sync reset.
*/
`timescale 1ns/1ns
`default_nettype none
module uhs_props (
	input wire logic clock,
	input wire logic rst,
	input wire logic masterClear,
	input wire logic hostReadStrobeN,
	input wire logic hostReadStrobe,
	input wire logic hostDataOe,
	input wire logic transceiverDisableN,
	input wire logic interruptOut,
	input wire logic ctsN,
	input wire logic dtrN,
	input wire logic rtsN,
	input wire logic txSixteenxClockOut,
	input wire logic txAllowed,
	input wire logic thrWrite,
	input wire logic [7:0] lineControl
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);
	// Pins reach the logic two edges late, hence depth-2 pasts
	property p_oe_pair;
		transceiverDisableN == hostDataOe;
	endproperty
	a_oe_pair: assert property (p_oe_pair)
		else $error("driver disable differs from bus enable");
	property p_oe_src;
		hostDataOe |-> $past(hostReadStrobe || !hostReadStrobeN, 2);
	endproperty
	a_oe_src: assert property (p_oe_src)
		else $error("bus driven without a read strobe");
	property p_clr_pins;
		$past(masterClear, 2) && $past(masterClear, 3) |-> dtrN && rtsN;
	endproperty
	a_clr_pins: assert property (p_clr_pins)
		else $error("modem outputs active under master clear");
	property p_clr_int;
		$past(masterClear, 2) && $past(masterClear, 3)
			|-> !interruptOut && !hostDataOe;
	endproperty
	a_clr_int: assert property (p_clr_int)
		else $error("interrupt or bus active under master clear");
	property p_rst_out;
		$past(rst) |-> !txSixteenxClockOut && !interruptOut && dtrN && rtsN;
	endproperty
	a_rst_out: assert property (p_rst_out)
		else $error("outputs not at reset levels");
	property p_thr_pulse;
		thrWrite |=> !thrWrite;
	endproperty
	a_thr_pulse: assert property (p_thr_pulse)
		else $error("transmit write longer than one cycle");
	property p_thr_dlab;
		thrWrite |-> !lineControl[uhs_pkg::LCR_DLAB];
	endproperty
	a_thr_dlab: assert property (p_thr_dlab)
		else $error("transmit write while divisor selected");
	property p_tx_gate;
		$past(!ctsN, 2) && $past(!ctsN, 3) |-> txAllowed;
	endproperty
	a_tx_gate: assert property (p_tx_gate)
		else $error("transmit blocked with send-clear active");
endmodule
bind uhs_top uhs_props chk (.clock, .rst, .masterClear, .hostReadStrobeN,
	.hostReadStrobe, .hostDataOe, .transceiverDisableN, .interruptOut,
	.ctsN, .dtrN, .rtsN, .txSixteenxClockOut, .txAllowed, .thrWrite,
	.lineControl);
`default_nettype wire

/* File: uhs_top.sv */
/*
 Host-side select, register and modem-pin logic of a one-channel UART:
 strobe-latched select decode, tri-state data bus as three signals,
 interrupt identity and output, modem status flags, terminal-ready and
 send-request pins, transmit gating, and the 16x transmit clock.
 Assumes the framer and FIFOs around it run on the same clock and
 give their status as plain levels; host and modem pins are async.
*/
//
// Functional notes
// - Select lines choose the accessed register
// - Strobe low: select inputs pass straight through
// - Strobe rising edge latches and holds selects
// - Selected only when A, B high, low-enable low
// - Transmit clock is reference divided by divisor
// - Status bit 4 clear-to-send, bit 0 change
// - Send-clear change interrupts only without auto mode
// - Auto mode: send-clear input gates transmitter
// - Status bit 7 carrier, bit 3 change
// - Status bit 5 set-ready, bit 1 change
// - Carrier or set-ready change interrupts when enabled
// - Terminal-ready follows control bit, off in loopback
// - Interrupt output high while enabled cause pending
// - Interrupt drops when serviced or on reset
// - Master clear resets registers except scratch and divisor, and pin levels
// - Transceiver disable low unless host is reading
// - Eight-bit two-way host data bus
// - Either read strobe polarity reads when selected
// - Either write strobe polarity writes when selected
// - Auto mode: receive threshold drops send request
`timescale 1ns/1ns
`default_nettype none

module uhs_top (
	input wire logic clock,
	input wire logic rst,
	input wire logic masterClear,
	input wire logic [2:0] registerSelectLines,
	input wire logic selectLatchStrobeN,
	input wire logic chipEnableHighA,
	input wire logic chipEnableHighB,
	input wire logic chipEnableLowN,
	input wire logic hostReadStrobeN,
	input wire logic hostReadStrobe,
	input wire logic hostWriteStrobeN,
	input wire logic hostWriteStrobe,
	input wire logic [7:0] hostDataIn,
	output logic [7:0] hostDataOut,
	output logic hostDataOe,
	output logic transceiverDisableN,
	output logic interruptOut,
	input wire logic ctsN,
	input wire logic dsrN,
	input wire logic dcdN,
	input wire logic riN,
	output logic dtrN,
	output logic rtsN,
	output logic txSixteenxClockOut,
	output logic txAllowed,
	input wire logic fifoMode,
	input wire logic rxDataReady,
	input wire logic rxTimeout,
	input wire logic rxLineError,
	input wire logic rxAboveThreshold,
	input wire logic thrEmpty,
	input wire logic [7:0] rxHoldData,
	input wire logic [7:0] lineStatus,
	output logic thrWrite,
	output logic [7:0] thrData,
	output logic [7:0] lineControl
);

	typedef struct packed {
		logic [uhs_pkg::SYNC_W-1:0] sync1;
		logic [uhs_pkg::SYNC_W-1:0] sync2;
		logic [2:0] heldAddr;
		logic [2:0] heldCs;
		logic rdPrev;
		logic wrPrev;
		logic [2:0] wrAddr;
		logic [7:0] wrData;
		logic [7:0] dataOut;
		logic [7:0] ier;
		logic [7:0] lcr;
		logic [7:0] modem_control_reg;
		logic [7:0] spr;
		logic [7:0] dll;
		logic [7:0] dlm;
		logic [3:0] modemPrev;
		logic [3:0] delta;
		logic thrPend;
		logic thrEmptyPrev;
		logic thrStrobe;
		logic [7:0] thrByte;
	} uhs_state_type;

	uhs_state_type st_q;
	uhs_state_type st_d;

	// Synchronised pin copies, read only from the second stage
	logic [2:0] addrS;
	logic strobeS;
	logic csAS;
	logic csBS;
	logic csLowNS;
	logic rdNS;
	logic rdS;
	logic wrNS;
	logic wrS;
	logic [7:0] dataS;
	logic ctsNS;
	logic dsrNS;
	logic dcdNS;
	logic riNS;
	logic clearS;

	logic [2:0] effAddr;
	logic [2:0] effCs;
	logic selected;
	logic rdNow;
	logic wrNow;
	logic rdStart;
	logic wrEnd;
	logic dlab;
	logic loopback;
	logic autoFlow;
	logic [3:0] modemNow;
	logic [3:0] modemChange;
	logic modemInt;
	logic [3:0] isrId;
	logic [7:0] isrByte;
	logic [7:0] msrByte;
	logic [7:0] readMux;

	uhs_baud_if baudLink ();

	uhs_baud_gen baudGen (
		.clock(clock),
		.rst(rst),
		.link(baudLink)
	);

	// Unpack second stage; first stage feeds only the second
	assign {clearS, riNS, dcdNS, dsrNS, ctsNS, dataS, wrS, wrNS, rdS,
		rdNS, csLowNS, csBS, csAS, strobeS, addrS} = st_q.sync2;

	// Strobe low passes selects, high holds the value at its rise
	assign effAddr = strobeS ? st_q.heldAddr : addrS;
	assign effCs = strobeS ? st_q.heldCs : {csLowNS, csBS, csAS};
	assign selected = effCs[0] & effCs[1] & ~effCs[2];

	// Either strobe polarity counts; host ties the other off
	assign rdNow = selected & (rdS | ~rdNS);
	assign wrNow = selected & (wrS | ~wrNS);
	assign rdStart = rdNow & ~st_q.rdPrev;
	assign wrEnd = st_q.wrPrev & ~wrNow;

	assign dlab = st_q.lcr[uhs_pkg::LCR_DLAB];
	assign loopback = st_q.modem_control_reg[uhs_pkg::MCR_LOOP];
	assign autoFlow = st_q.modem_control_reg[uhs_pkg::MCR_AFE];

	// Active-true modem levels; loopback feeds back the control bits
	always_comb begin
		if (loopback) begin
			modemNow[uhs_pkg::MDM_CTS] = st_q.modem_control_reg[uhs_pkg::MCR_RTS];
			modemNow[uhs_pkg::MDM_DSR] = st_q.modem_control_reg[uhs_pkg::MCR_DTR];
			modemNow[uhs_pkg::MDM_RI] = st_q.modem_control_reg[uhs_pkg::MCR_OUT1];
			modemNow[uhs_pkg::MDM_DCD] = st_q.modem_control_reg[uhs_pkg::MCR_OUT2];
		end else begin
			modemNow[uhs_pkg::MDM_CTS] = ~ctsNS;
			modemNow[uhs_pkg::MDM_DSR] = ~dsrNS;
			modemNow[uhs_pkg::MDM_RI] = ~riNS;
			modemNow[uhs_pkg::MDM_DCD] = ~dcdNS;
		end
	end

	// Change detect; ring flags only its trailing edge
	always_comb begin
		modemChange = modemNow ^ st_q.modemPrev;
		modemChange[uhs_pkg::MDM_RI] = st_q.modemPrev[uhs_pkg::MDM_RI] &
			~modemNow[uhs_pkg::MDM_RI];
	end

	// Send-clear change is silent while auto flow owns that pin
	assign modemInt = st_q.delta[uhs_pkg::MDM_DCD] |
		st_q.delta[uhs_pkg::MDM_DSR] |
		st_q.delta[uhs_pkg::MDM_RI] |
		(st_q.delta[uhs_pkg::MDM_CTS] & ~autoFlow);

	// Identity by fixed priority, highest first
	always_comb begin
		if (st_q.ier[uhs_pkg::IER_LINE] & rxLineError) begin
			isrId = uhs_pkg::ISR_LINE;
		end else if (st_q.ier[uhs_pkg::IER_RX] & rxDataReady) begin
			isrId = uhs_pkg::ISR_RXDATA;
		end else if (st_q.ier[uhs_pkg::IER_RX] & rxTimeout & fifoMode) begin
			isrId = uhs_pkg::ISR_TIMEOUT;
		end else if (st_q.ier[uhs_pkg::IER_THRE] & st_q.thrPend) begin
			isrId = uhs_pkg::ISR_THRE;
		end else if (st_q.ier[uhs_pkg::IER_MODEM] & modemInt) begin
			isrId = uhs_pkg::ISR_MODEM;
		end else begin
			isrId = uhs_pkg::ISR_NONE;
		end
	end

	assign isrByte = {fifoMode ? uhs_pkg::ISR_FIFO_ON : uhs_pkg::ISR_FIFO_OFF,
		2'h0, isrId};
	assign msrByte = {modemNow[uhs_pkg::MDM_DCD],
		modemNow[uhs_pkg::MDM_RI],
		modemNow[uhs_pkg::MDM_DSR],
		modemNow[uhs_pkg::MDM_CTS],
		st_q.delta};

	// Read data select; divisor latches overlay the first two slots
	always_comb begin
		if (effAddr == uhs_pkg::REG_RXTX) begin
			readMux = dlab ? st_q.dll : rxHoldData;
		end else if (effAddr == uhs_pkg::REG_IER) begin
			readMux = dlab ? st_q.dlm : st_q.ier;
		end else if (effAddr == uhs_pkg::REG_ISR) begin
			readMux = isrByte;
		end else if (effAddr == uhs_pkg::REG_LCR) begin
			readMux = st_q.lcr;
		end else if (effAddr == uhs_pkg::REG_MCR) begin
			readMux = st_q.modem_control_reg;
		end else if (effAddr == uhs_pkg::REG_LSR) begin
			readMux = lineStatus;
		end else if (effAddr == uhs_pkg::REG_MSR) begin
			readMux = msrByte;
		end else begin
			readMux = st_q.spr;
		end
	end

	// Next state of the whole block
	always_comb begin
		st_d = st_q;
		st_d.sync1 = {masterClear, riN, dcdN, dsrN, ctsN, hostDataIn,
			hostWriteStrobe, hostWriteStrobeN, hostReadStrobe,
			hostReadStrobeN, chipEnableLowN, chipEnableHighB,
			chipEnableHighA, selectLatchStrobeN, registerSelectLines};
		st_d.sync2 = st_q.sync1;
		// Hold register tracks live selects while the strobe is low
		if (!strobeS) begin
			st_d.heldAddr = addrS;
			st_d.heldCs = {csLowNS, csBS, csAS};
		end
		st_d.rdPrev = rdNow;
		st_d.wrPrev = wrNow;
		st_d.thrStrobe = 1'b0;
		st_d.thrEmptyPrev = thrEmpty;
		st_d.modemPrev = modemNow;
		// Data captured while the strobe is on, committed at its end
		if (wrNow) begin
			st_d.wrAddr = effAddr;
			st_d.wrData = dataS;
		end
		// Reads sample once at the start; side effects clear there too
		if (rdStart) begin
			st_d.dataOut = readMux;
			if (effAddr == uhs_pkg::REG_MSR) begin
				st_d.delta = 4'h0;
			end
			if (effAddr == uhs_pkg::REG_ISR && isrId == uhs_pkg::ISR_THRE) begin
				st_d.thrPend = 1'b0;
			end
		end
		if (wrEnd) begin
			if (st_q.wrAddr == uhs_pkg::REG_RXTX) begin
				if (dlab) begin
					st_d.dll = st_q.wrData;
				end else begin
					st_d.thrStrobe = 1'b1;
					st_d.thrByte = st_q.wrData;
					st_d.thrPend = 1'b0;
				end
			end else if (st_q.wrAddr == uhs_pkg::REG_IER) begin
				if (dlab) begin
					st_d.dlm = st_q.wrData;
				end else begin
					st_d.ier = st_q.wrData;
				end
			end else if (st_q.wrAddr == uhs_pkg::REG_LCR) begin
				st_d.lcr = st_q.wrData;
			end else if (st_q.wrAddr == uhs_pkg::REG_MCR) begin
				st_d.modem_control_reg = st_q.wrData;
			end else if (st_q.wrAddr == uhs_pkg::REG_SPR) begin
				st_d.spr = st_q.wrData;
			end
		end
		// Events after clears: a change in the clearing cycle survives
		st_d.delta = st_d.delta | modemChange;
		if ((thrEmpty & ~st_q.thrEmptyPrev) |
			(thrEmpty & st_d.ier[uhs_pkg::IER_THRE] &
			~st_q.ier[uhs_pkg::IER_THRE])) begin
			st_d.thrPend = 1'b1;
		end
		// Master clear keeps scratch and divisor, clears the rest
		if (clearS) begin
			st_d.ier = uhs_pkg::REG_RESET;
			st_d.lcr = uhs_pkg::REG_RESET;
			st_d.modem_control_reg = uhs_pkg::REG_RESET;
			st_d.delta = 4'h0;
			st_d.thrPend = 1'b0;
			st_d.thrStrobe = 1'b0;
			st_d.dataOut = uhs_pkg::REG_RESET;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			// Idle sync image, else zeros look like active modem pins
			st_q <= '{sync1: uhs_pkg::SYNC_IDLE, sync2: uhs_pkg::SYNC_IDLE,
				default: '0};
		end else begin
			st_q <= st_d;
		end
	end

	assign baudLink.divisor = {st_q.dlm, st_q.dll};
	assign txSixteenxClockOut = baudLink.sixteenx;

	// Bus drive only inside a selected read; enable is the TRANSCEIVER_DISABLE_N level
	assign hostDataOut = st_q.dataOut;
	assign hostDataOe = rdNow & ~clearS;
	assign transceiverDisableN = rdNow & ~clearS;

	// Synced master clear forces the pin low without waiting an edge
	assign interruptOut = (isrId != uhs_pkg::ISR_NONE) & ~clearS;

	// Modem outputs inactive high in loopback or when bit clear
	assign dtrN = ~st_q.modem_control_reg[uhs_pkg::MCR_DTR] | loopback | clearS;
	assign rtsN = ~st_q.modem_control_reg[uhs_pkg::MCR_RTS] | loopback | clearS |
		(autoFlow & rxAboveThreshold);

	// Auto flow lets the send-clear level decide; else always allowed
	assign txAllowed = ~autoFlow | modemNow[uhs_pkg::MDM_CTS];

	assign thrWrite = st_q.thrStrobe;
	assign thrData = st_q.thrByte;
	assign lineControl = st_q.lcr;

endmodule

`default_nettype wire
